// *** docp_pkg.sv ***
// Shared constants and carrier types for the directional overcurrent pick-up stage.
// Assumes one 40 MHz clock and measurements already scaled by the front end.
package docp_pkg;
  // Clock and processing cycle
  localparam int CLK_HZ          = 40_000_000;
  localparam int CYCLE_US        = 5000;
  localparam int CYCLE_CLKS_DEF  = CLK_HZ / 1_000_000 * CYCLE_US;
  localparam int MEM_MS          = 500;
  localparam int MEM_CYC         = MEM_MS * 1000 / CYCLE_US;
  localparam int PRE_MS          = 100;
  localparam int PRE_CYC         = PRE_MS * 1000 / CYCLE_US;
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_SECTOR = 8'h04;
  localparam logic [7:0] A_CENTER = 8'h08;
  localparam logic [7:0] A_ISET   = 8'h0C;
  localparam logic [7:0] A_HARM   = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_ANGLE  = 8'h18;
  localparam logic [7:0] A_EVENT  = 8'h1C;
  // Control fields
  localparam int CTRL_NONDIR  = 0;
  localparam int CTRL_INRUSH  = 1;
  // Setting limits and resets (angles 0.1 deg, current 0.01 In, harmonic 0.01 %)
  localparam logic [11:0] SEC_MIN   = 12'h00A;
  localparam logic [11:0] SEC_MAX   = 12'h6A4;
  localparam logic [11:0] SEC_RST   = 12'h370;
  localparam logic signed [11:0] CEN_MIN = -12'sh708;
  localparam logic signed [11:0] CEN_MAX = 12'sh708;
  localparam logic signed [11:0] CEN_RST = 12'sh000;
  localparam logic [15:0] ISET_MIN  = 16'h000A;
  localparam logic [15:0] ISET_MAX  = 16'h0FA0;
  localparam logic [15:0] ISET_RST  = 16'h0078;
  localparam logic [15:0] HARM_MIN  = 16'h000A;
  localparam logic [15:0] HARM_MAX  = 16'h1388;
  localparam logic [15:0] HARM_RST  = 16'h000A;
  localparam int          RESET_PCT = 97;
  localparam logic [11:0] HYST      = 12'h014;
  localparam logic signed [13:0] HALF_TURN = 14'sh0708;
  localparam logic signed [13:0] FULL_TURN = 14'sh0E10;
  localparam logic [15:0] VLOW      = 16'h0064;
  localparam logic [1:0]  RESP_OK   = 2'b00;
  localparam logic [1:0]  RESP_ERR  = 2'b10;

  // Pre-processed measurements of one cycle
  typedef struct packed {
    logic [15:0]        phase_a_current;
    logic [15:0]        phase_b_current;
    logic [15:0]        phase_c_current;
    logic signed [11:0] positive_sequence_current;
    logic signed [11:0] positive_sequence_voltage;
    logic [15:0]        voltage_magnitude;
    logic               voltage_valid;
    logic               line_to_line_only_mode;
    logic signed [11:0] healthy_ll_angle;
    logic               short_circuit;
    logic signed [11:0] impedance_angle;
    logic [15:0]        harmonic_ratio;
    logic               ext_block;
  } docp_meas_t;

  // Blocking event record
  typedef struct packed {
    logic [15:0] cur_a;
    logic [15:0] cur_b;
    logic [15:0] cur_c;
    logic [2:0]  fault_type;
  } docp_event_t;
endpackage

// *** docp_stage.sv ***
// Directional overcurrent pick-up stage with AXI4-Lite settings and status.
// Assumes measurements are synchronous to aclk and stable across a processing cycle.
`timescale 1ns/1ps
`default_nettype none
module docp_stage
  import docp_pkg::*;
#(
  parameter int CYCLE_CLKS = CYCLE_CLKS_DEF
) (
  input  wire logic        aclk,          // System clock
  input  wire logic        aresetn,       // Sync reset, low
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output var  logic        s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Byte enables
  input  wire logic        s_axi_wvalid,  // Write data valid
  output var  logic        s_axi_wready,  // Write data ready
  output var  logic [1:0]  s_axi_bresp,   // Write response
  output var  logic        s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output var  logic        s_axi_arready, // Read address ready
  output var  logic [31:0] s_axi_rdata,   // Read data
  output var  logic [1:0]  s_axi_rresp,   // Read response
  output var  logic        s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  input  wire docp_meas_t  meas_i,        // Measurements
  output var  logic        pickup_o,      // Magnitude pick-up
  output var  logic        start_o,       // Start indication
  output var  logic        blocked_o,     // Blocked indication
  output var  logic        trip_allow_o,  // Delay timing may run
  output var  logic        timer_reset_o, // Delay reset pulse
  output var  logic        mem_active_o,  // Angle memory in use
  output var  logic        block_event_o, // Blocking event pulse
  output var  docp_event_t event_o        // Blocking event data
);

  // Wrap an angle difference into -180..180 degrees
  function automatic logic signed [11:0] wrap_ang(input logic signed [13:0] d);
    logic signed [13:0] t;
    t = d;
    if (t > HALF_TURN) t = t - FULL_TURN;
    if (t > HALF_TURN) t = t - FULL_TURN;
    if (t < -HALF_TURN) t = t + FULL_TURN;
    if (t < -HALF_TURN) t = t + FULL_TURN;
    return t[11:0];
  endfunction

  // Clamp an unsigned setting into its range
  function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction

  // Magnitude of a wrapped angle
  function automatic logic [11:0] abs_ang(input logic signed [11:0] a);
    return a[11] ? 12'(-a) : 12'(a);
  endfunction

  // Settings registers
  logic        nondir_r, nondir_nxt;
  logic        inrush_r, inrush_nxt;
  logic [11:0] sector_r, sector_nxt;
  logic signed [11:0] center_r, center_nxt;
  logic [15:0] iset_r, iset_nxt;
  logic [15:0] harm_r, harm_nxt;
  // Bus state
  logic        awready_r, awready_nxt;
  logic        wready_r, wready_nxt;
  logic        aw_got_r, aw_got_nxt;
  logic        w_got_r, w_got_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  // Protection state
  logic [17:0] div_r, div_nxt;
  logic        cyc_en_r, cyc_en_nxt;
  logic        blk_r, blk_nxt;
  logic        pickup_r, pickup_nxt;
  logic        start_r, start_nxt;
  logic        blocked_r, blocked_nxt;
  logic        in_sec_r, in_sec_nxt;
  logic        trip_r, trip_nxt;
  logic        treset_r, treset_nxt;
  logic        mem_r, mem_nxt;
  logic        mem_done_r, mem_done_nxt;
  logic [7:0]  mem_cnt_r, mem_cnt_nxt;
  logic signed [11:0] mem_ang_r, mem_ang_nxt;
  logic signed [11:0] op_ang_r, op_ang_nxt;
  logic [4:0]  hptr_r, hptr_nxt;
  logic        bev_r, bev_nxt;
  docp_event_t ev_r, ev_nxt;
  logic signed [11:0] hist_r [PRE_CYC];
  logic [15:0] wval;
  logic        wr_go;
  logic        rd_go;

  // Bus handshakes and register writes
  always_comb begin
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    aw_got_nxt  = aw_got_r;
    w_got_nxt   = w_got_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    nondir_nxt  = nondir_r;
    inrush_nxt  = inrush_r;
    sector_nxt  = sector_r;
    center_nxt  = center_r;
    iset_nxt    = iset_r;
    harm_nxt    = harm_r;
    wval        = wdata_r[15:0];
    wr_go       = aw_got_r && w_got_r && !bvalid_r;
    // Accept address and data in either order
    awready_nxt = !aw_got_r && !s_axi_awready && !bvalid_r;
    wready_nxt  = !w_got_r && !s_axi_wready && !bvalid_r;
    if (s_axi_awvalid && awready_r) begin
      aw_got_nxt  = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r) begin
      w_got_nxt  = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wready_nxt = 1'b0;
      if (!s_axi_wstrb[0]) wdata_nxt[7:0] = wdata_r[7:0];
      if (!s_axi_wstrb[1]) wdata_nxt[15:8] = wdata_r[15:8];
    end
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OK;
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      case (awaddr_r)
        A_CTRL: begin
          nondir_nxt = wval[CTRL_NONDIR];
          inrush_nxt = wval[CTRL_INRUSH];
        end
        A_SECTOR: sector_nxt = 12'(clamp_u(wval, 16'(SEC_MIN), 16'(SEC_MAX)));
        A_CENTER: begin
          // Signed clamp of the sector centre
          if ($signed(wval) < $signed(16'(CEN_MIN))) center_nxt = CEN_MIN;
          else if ($signed(wval) > $signed(16'(CEN_MAX))) center_nxt = CEN_MAX;
          else center_nxt = wval[11:0];
        end
        A_ISET: iset_nxt = clamp_u(wval, ISET_MIN, ISET_MAX);
        A_HARM: harm_nxt = clamp_u(wval, HARM_MIN, HARM_MAX);
        A_STATUS, A_ANGLE, A_EVENT: bresp_nxt = RESP_OK;
        default: bresp_nxt = RESP_ERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
  end

  // Read channel
  always_comb begin
    arready_nxt = !rvalid_r && !arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    rd_go       = s_axi_arvalid && arready_r;
    if (rd_go) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = RESP_OK;
      case (s_axi_araddr)
        A_CTRL:   rdata_nxt = {30'h0, inrush_r, nondir_r};
        A_SECTOR: rdata_nxt = {20'h0, sector_r};
        A_CENTER: rdata_nxt = {{20{center_r[11]}}, center_r};
        A_ISET:   rdata_nxt = {16'h0, iset_r};
        A_HARM:   rdata_nxt = {16'h0, harm_r};
        A_STATUS: rdata_nxt = {25'h0, mem_done_r, mem_r, trip_r, in_sec_r, blocked_r,
                               start_r, pickup_r};
        A_ANGLE:  rdata_nxt = {{20{op_ang_r[11]}}, op_ang_r};
        A_EVENT:  rdata_nxt = {29'h0, ev_r.fault_type};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_ERR;
        end
      endcase
    end
    if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
  end

  // Protection next state, evaluated once per processing cycle
  logic        over_a, over_b, over_c, hold_any;
  logic [15:0] rel_lvl;
  logic        low_v;
  logic signed [11:0] ref_ang;
  logic signed [11:0] diff;
  logic [11:0] mag;
  always_comb begin
    div_nxt      = div_r;
    cyc_en_nxt   = 1'b0;
    blk_nxt      = blk_r;
    pickup_nxt   = pickup_r;
    start_nxt    = start_r;
    blocked_nxt  = blocked_r;
    in_sec_nxt   = in_sec_r;
    trip_nxt     = trip_r;
    treset_nxt   = 1'b0;
    mem_nxt      = mem_r;
    mem_done_nxt = mem_done_r;
    mem_cnt_nxt  = mem_cnt_r;
    mem_ang_nxt  = mem_ang_r;
    op_ang_nxt   = op_ang_r;
    hptr_nxt     = hptr_r;
    bev_nxt      = 1'b0;
    ev_nxt       = ev_r;
    // Program cycle divider
    if (div_r == 18'(CYCLE_CLKS - 1)) begin
      div_nxt    = 18'h0;
      cyc_en_nxt = 1'b1;
    end else begin
      div_nxt = div_r + 18'h1;
    end
    rel_lvl  = 16'((32'(iset_r) * RESET_PCT) / 100);
    over_a   = meas_i.phase_a_current > iset_r;
    over_b   = meas_i.phase_b_current > iset_r;
    over_c   = meas_i.phase_c_current > iset_r;
    hold_any = (meas_i.phase_a_current >= rel_lvl) || (meas_i.phase_b_current >= rel_lvl) ||
               (meas_i.phase_c_current >= rel_lvl);
    low_v    = meas_i.voltage_magnitude < VLOW;
    // Reference angle selection
    if (meas_i.short_circuit) ref_ang = meas_i.impedance_angle;
    else if (mem_r) ref_ang = mem_ang_r;
    else if (mem_done_r) ref_ang = 12'sh000;
    else if (!meas_i.voltage_valid && meas_i.line_to_line_only_mode)
      ref_ang = meas_i.healthy_ll_angle;
    else ref_ang = meas_i.positive_sequence_voltage;
    diff = wrap_ang(14'(meas_i.positive_sequence_current) - 14'(center_r) - 14'(ref_ang));
    mag  = abs_ang(diff);
    if (cyc_en_r) begin
      // Block is taken before the rest of the stage; 5 ms cycle meets the lead time
      blk_nxt = meas_i.ext_block || (inrush_r && meas_i.harmonic_ratio > harm_r);
      op_ang_nxt = diff;
      // Sector test with hysteresis on the way out
      if (in_sec_r) in_sec_nxt = mag <= sector_r + HYST;
      else in_sec_nxt = mag <= sector_r;
      // Pick-up with built-in reset ratio
      if (pickup_r) pickup_nxt = hold_any;
      else pickup_nxt = over_a || over_b || over_c;
      // Angle history while healthy
      if (!pickup_r) begin
        hptr_nxt = (hptr_r == 5'(PRE_CYC - 1)) ? 5'h0 : hptr_r + 5'h1;
      end
      // Angle memory on collapsed voltage
      if (pickup_nxt && !pickup_r) begin
        mem_ang_nxt = hist_r[hptr_r];
        mem_done_nxt = 1'b0;
      end
      if (pickup_r && pickup_nxt && low_v && !mem_r && !mem_done_r) begin
        mem_nxt     = 1'b1;
        mem_cnt_nxt = 8'h0;
      end else if (mem_r && !pickup_nxt) begin
        mem_nxt = 1'b0;
      end else if (mem_r) begin
        if (mem_cnt_r == 8'(MEM_CYC - 1)) begin
          mem_nxt      = 1'b0;
          mem_done_nxt = 1'b1;
        end else begin
          mem_cnt_nxt = mem_cnt_r + 8'h1;
        end
      end
      if (!pickup_r || !low_v) begin
        if (!mem_r) mem_done_nxt = 1'b0;
      end
      // Start, blocked and delay timing
      start_nxt = pickup_nxt;
      if (pickup_nxt && !pickup_r && blk_nxt) blocked_nxt = 1'b1;
      else if (start_r && blk_nxt && !blocked_r) begin
        blocked_nxt = 1'b1;
        treset_nxt  = trip_r;
      end else if (!pickup_nxt || !blk_nxt) blocked_nxt = 1'b0;
      trip_nxt = pickup_nxt && !blocked_nxt && (nondir_r || in_sec_nxt);
      // Blocking event record
      if (blocked_nxt && !blocked_r) begin
        bev_nxt = 1'b1;
        ev_nxt  = '{cur_a: meas_i.phase_a_current, cur_b: meas_i.phase_b_current,
                    cur_c: meas_i.phase_c_current,
                    fault_type: {meas_i.phase_c_current >= rel_lvl,
                                 meas_i.phase_b_current >= rel_lvl,
                                 meas_i.phase_a_current >= rel_lvl}};
      end
    end
  end

  // Angle history array, written while no fault is present
  always_ff @(posedge aclk) begin
    if (cyc_en_r && !pickup_r) hist_r[hptr_r] <= meas_i.positive_sequence_voltage;
  end

  // Register all state except the angle history array
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nondir_r   <= 1'b0;
      inrush_r   <= 1'b0;
      sector_r   <= SEC_RST;
      center_r   <= CEN_RST;
      iset_r     <= ISET_RST;
      harm_r     <= HARM_RST;
      awready_r  <= 1'b0;
      wready_r   <= 1'b0;
      aw_got_r   <= 1'b0;
      w_got_r    <= 1'b0;
      awaddr_r   <= 8'h00;
      wdata_r    <= 32'h0000_0000;
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OK;
      arready_r  <= 1'b0;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= RESP_OK;
      div_r      <= 18'h0;
      cyc_en_r   <= 1'b0;
      blk_r      <= 1'b0;
      pickup_r   <= 1'b0;
      start_r    <= 1'b0;
      blocked_r  <= 1'b0;
      in_sec_r   <= 1'b0;
      trip_r     <= 1'b0;
      treset_r   <= 1'b0;
      mem_r      <= 1'b0;
      mem_done_r <= 1'b0;
      mem_cnt_r  <= 8'h0;
      mem_ang_r  <= 12'sh000;
      op_ang_r   <= 12'sh000;
      hptr_r     <= 5'h0;
      bev_r      <= 1'b0;
      ev_r       <= '0;
    end else begin
      nondir_r   <= nondir_nxt;
      inrush_r   <= inrush_nxt;
      sector_r   <= sector_nxt;
      center_r   <= center_nxt;
      iset_r     <= iset_nxt;
      harm_r     <= harm_nxt;
      awready_r  <= awready_nxt;
      wready_r   <= wready_nxt;
      aw_got_r   <= aw_got_nxt;
      w_got_r    <= w_got_nxt;
      awaddr_r   <= awaddr_nxt;
      wdata_r    <= wdata_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      arready_r  <= arready_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
      div_r      <= div_nxt;
      cyc_en_r   <= cyc_en_nxt;
      blk_r      <= blk_nxt;
      pickup_r   <= pickup_nxt;
      start_r    <= start_nxt;
      blocked_r  <= blocked_nxt;
      in_sec_r   <= in_sec_nxt;
      trip_r     <= trip_nxt;
      treset_r   <= treset_nxt;
      mem_r      <= mem_nxt;
      mem_done_r <= mem_done_nxt;
      mem_cnt_r  <= mem_cnt_nxt;
      mem_ang_r  <= mem_ang_nxt;
      op_ang_r   <= op_ang_nxt;
      hptr_r     <= hptr_nxt;
      bev_r      <= bev_nxt;
      ev_r       <= ev_nxt;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign pickup_o      = pickup_r;
  assign start_o       = start_r;
  assign blocked_o     = blocked_r;
  assign trip_allow_o  = trip_r;
  assign timer_reset_o = treset_r;
  assign mem_active_o  = mem_r;
  assign block_event_o = bev_r;
  assign event_o       = ev_r;

endmodule
`default_nettype wire

// *** docp_front.sv ***
// Front-end model feeding pre-processed measurements to the stage.
// Assumes the bench sets the raw scene on rising aclk edges.
`timescale 1ns/1ps
`default_nettype none
module docp_front
  import docp_pkg::*;
(
  input  wire logic       aclk,  // Clock
  input  wire docp_meas_t raw_i, // Scene from bench
  output var  docp_meas_t meas_o // Measurements to stage
);
  // Publish each scene one clock later; block level passes unchanged, well ahead of delays
  always_ff @(posedge aclk) begin
    meas_o               <= raw_i;
    meas_o.voltage_valid <= raw_i.voltage_magnitude >= VLOW;
  end
endmodule
`default_nettype wire

// *** docp_stage_props.sv ***
// Port checker for the overcurrent pick-up stage.
// Assumes it is bound into every stage instance.
`timescale 1ns/1ps
`default_nettype none
module docp_stage_props
  import docp_pkg::*;
(
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Reset, low
  input wire logic        s_axi_bvalid,  // Write resp valid
  input wire logic        s_axi_bready,  // Write resp ready
  input wire logic [1:0]  s_axi_bresp,   // Write resp
  input wire logic        s_axi_rvalid,  // Read valid
  input wire logic        s_axi_rready,  // Read ready
  input wire logic [31:0] s_axi_rdata,   // Read data
  input wire logic        pickup_o,      // Pick-up
  input wire logic        start_o,       // Start
  input wire logic        blocked_o,     // Blocked
  input wire logic        trip_allow_o,  // Trip allowed
  input wire logic        timer_reset_o, // Delay reset
  input wire logic        mem_active_o,  // Memory in use
  input wire logic        block_event_o, // Event pulse
  input wire docp_event_t event_o        // Event data
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Indication relations
  start_pickup_a: assert property (start_o == pickup_o)
    else $error("start differs from pickup");
  start_blocked_a: assert property (blocked_o |-> start_o && pickup_o)
    else $error("blocked without start");
  trip_gate_a: assert property (trip_allow_o |-> pickup_o && !blocked_o)
    else $error("trip allowed without pickup");
  timer_reset_a: assert property (timer_reset_o |-> blocked_o && $past(trip_allow_o) ##1 !timer_reset_o)
    else $error("bad delay reset pulse");
  block_event_a: assert property (block_event_o |-> blocked_o && event_o.fault_type != 3'h0 ##1 !block_event_o)
    else $error("bad blocking event");
  early_block_a: assert property ($rose(pickup_o) && blocked_o |-> !timer_reset_o)
    else $error("delay reset on blocked pick-up");
  mem_pickup_a: assert property (mem_active_o |-> pickup_o)
    else $error("memory without pickup");
  cycle_hold_a: assert property ($changed(pickup_o) |=> $stable(pickup_o) [*8])
    else $error("pickup changed within a cycle");
  // Bus answers hold until taken
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule
bind docp_stage docp_stage_props u_props (.*);
`default_nettype wire

// *** test_docp_stage.sv ***
// Self-checking bench for the overcurrent pick-up stage.
// Assumes stage, checker and front-end model compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_docp_stage
  import docp_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        pickup_o, start_o, blocked_o, trip_allow_o, timer_reset_o;
  logic        mem_active_o, block_event_o;
  docp_meas_t  raw = '0, meas_i;
  docp_event_t event_o;
  int          errors = 0, total_checks = 0, n_tr = 0, n_ev = 0;
  // Clock, pulse counters, instances
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    n_tr += timer_reset_o;
    n_ev += block_event_o;
  end
  docp_front FE (.aclk(aclk), .raw_i(raw), .meas_o(meas_i));
  docp_stage #(.CYCLE_CLKS(10)) DUT (.*);
  // Verdict and end of run
  task automatic end_of_test;
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Register write with expected response
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  // Register read into d and r
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK("rdata", e, d)
    `CHK("rresp", RESP_OK, r)
  endtask
  // New scene, then three processing cycles
  task automatic sc(input logic [15:0] b, input logic [11:0] i1, input logic [11:0] u1);
    @(posedge aclk);
    raw.phase_b_current <= b;
    raw.positive_sequence_current <= i1;
    raw.positive_sequence_voltage <= u1;
    repeat (30) @(posedge aclk);
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    end_of_test;
  end
  // Main sequence
  initial begin
    raw.voltage_magnitude = 16'h2710;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(A_CTRL, 32'h0);
    rc(A_SECTOR, 32'h370);
    rc(A_CENTER, 32'h0);
    rc(A_ISET, 32'h78);
    rc(A_HARM, 32'hA);
    rd(8'h20);
    `CHK("unmapped", RESP_ERR, r)
    wr(8'h20, 32'h1, RESP_ERR);
    wr(A_SECTOR, 32'h0, RESP_OK);
    rc(A_SECTOR, 32'h00A);
    wr(A_SECTOR, 32'h7D0, RESP_OK);
    rc(A_SECTOR, 32'h6A4);
    wr(A_CENTER, 32'hFFFF_F830, RESP_OK);
    rc(A_CENTER, 32'hFFFF_F8F8);
    wr(A_ISET, 32'h1388, RESP_OK);
    rc(A_ISET, 32'hFA0);
    wr(A_ISET, 32'h78, RESP_OK);
    wr(A_SECTOR, 32'h370, RESP_OK);
    wr(A_CENTER, 32'h0, RESP_OK);
    // Non-directional threshold and release
    wr(A_CTRL, 32'h1, RESP_OK);
    sc(16'h78, 12'h3E8, 12'h0);
    `CHK("at threshold", 1'b0, pickup_o)
    sc(16'h79, 12'h3E8, 12'h0);
    `CHK("pickup", 1'b1, pickup_o)
    `CHK("trip", 1'b1, trip_allow_o)
    `CHK("start", 1'b1, start_o)
    sc(16'h75, 12'h3E8, 12'h0);
    `CHK("hold", 1'b1, pickup_o)
    sc(16'h73, 12'h3E8, 12'h0);
    `CHK("release", 1'b0, pickup_o)
    // Directional sector, wrap and hysteresis
    wr(A_CTRL, 32'h0, RESP_OK);
    sc(16'h82, 12'h95C, 12'h6A4);
    `CHK("wrap", 1'b1, trip_allow_o)
    sc(16'h82, 12'h37A, 12'h0);
    `CHK("band", 1'b1, trip_allow_o)
    sc(16'h82, 12'h38E, 12'h0);
    `CHK("leave", 1'b0, trip_allow_o)
    sc(16'h82, 12'h37A, 12'h0);
    `CHK("no reentry", 1'b0, trip_allow_o)
    sc(16'h82, 12'h370, 12'h0);
    `CHK("edge", 1'b1, trip_allow_o)
    @(posedge aclk);
    raw.short_circuit <= 1'b1;
    raw.impedance_angle <= 12'h6A4;
    sc(16'h82, 12'h6A4, 12'h0);
    `CHK("impedance ref", 1'b1, trip_allow_o)
    @(posedge aclk);
    raw.short_circuit <= 1'b0;
    wr(A_CENTER, 32'h384, RESP_OK);
    sc(16'h82, 12'hC7C, 12'h0);
    `CHK("rotated out", 1'b0, trip_allow_o)
    sc(16'h82, 12'h37A, 12'h0);
    `CHK("rotated in", 1'b1, trip_allow_o)
    // External block after start, then before pick-up
    wr(A_CENTER, 32'h0, RESP_OK);
    wr(A_CTRL, 32'h1, RESP_OK);
    sc(16'h82, 12'h0, 12'h0);
    @(posedge aclk);
    raw.ext_block <= 1'b1;
    sc(16'h82, 12'h0, 12'h0);
    `CHK("blocked", 1'b1, blocked_o)
    `CHK("start kept", 1'b1, start_o)
    `CHK("trip", 1'b0, trip_allow_o)
    `CHK("delay reset", 1, n_tr)
    `CHK("event", 1, n_ev)
    `CHK("fault type", 3'h2, event_o.fault_type)
    `CHK("event current", 16'h82, event_o.cur_b)
    rc(A_EVENT, 32'h2);
    sc(16'h0, 12'h0, 12'h0);
    sc(16'h82, 12'h0, 12'h0);
    `CHK("blocked", 1'b1, blocked_o)
    `CHK("no delay reset", 1, n_tr)
    // Inrush harmonic blocking
    @(posedge aclk);
    raw.ext_block <= 1'b0;
    raw.harmonic_ratio <= 16'h64;
    wr(A_CTRL, 32'h3, RESP_OK);
    sc(16'h82, 12'h0, 12'h0);
    `CHK("inrush", 1'b1, blocked_o)
    @(posedge aclk);
    raw.harmonic_ratio <= 16'h5;
    sc(16'h82, 12'h0, 12'h0);
    `CHK("inrush off", 1'b0, blocked_o)
    `CHK("trip", 1'b1, trip_allow_o)
    // Healthy line-to-line reference, then angle memory and its expiry
    @(posedge aclk);
    raw.harmonic_ratio <= 16'h0;
    raw.voltage_magnitude <= 16'h32;
    raw.line_to_line_only_mode <= 1'b1;
    raw.healthy_ll_angle <= 12'h0C8;
    wr(A_CTRL, 32'h0, RESP_OK);
    sc(16'h0, 12'h0, 12'h0);
    `CHK("memory ends", 1'b0, mem_active_o)
    rc(A_ANGLE, 32'hFFFF_FF38);
    sc(16'h82, 12'h0, 12'h0);
    `CHK("memory", 1'b1, mem_active_o)
    repeat (900) @(posedge aclk);
    `CHK("memory held", 1'b1, mem_active_o)
    repeat (120) @(posedge aclk);
    `CHK("memory off", 1'b0, mem_active_o)
    rd(A_STATUS);
    `CHK("expired", 1'b1, d[6])
    end_of_test;
  end
endmodule
`default_nettype wire
